// >>> rtl/rtcif_line_if.sv
// rtcif_line_if: synchronised bus line levels and events between the sampler and the port logic
`default_nettype none
interface rtcif_line_if;
  logic scl;       // clock line level
  logic sda;       // data line level
  logic scl_rise;  // clock line rose
  logic scl_fall;  // clock line fell
  logic start;     // opening condition seen
  logic stop;      // closing condition seen
  modport src (output scl, sda, scl_rise, scl_fall, start, stop);
  modport dst (input  scl, sda, scl_rise, scl_fall, start, stop);
endinterface : rtcif_line_if
`default_nettype wire

// >>> rtl/rtcif_line_sync.sv
// rtcif_line_sync: two-flop synchronisers and event detection for the bus lines
`default_nettype none
module rtcif_line_sync
  import rtcif_pkg::*;
(
  input  wire logic   clock_in,   // system clock
  input  wire logic   arst_n_in,  // async reset, active low
  input  wire logic   scl_in,     // clock line pin
  input  wire logic   sda_in,     // data line pin
  rtcif_line_if.src   line        // synchronised levels and events
);
  logic [2:0] scl_sh;
  logic [2:0] sda_sh;

  // stage 0 is read only by stage 1; edges compare stages 1 and 2
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      scl_sh <= 3'h7;
      sda_sh <= 3'h7;
    end else begin
      scl_sh <= {scl_sh[1:0], scl_in};
      sda_sh <= {sda_sh[1:0], sda_in};
    end
  end

  assign line.scl      = scl_sh[1];
  assign line.sda      = sda_sh[1];
  assign line.scl_rise = scl_sh[1] & ~scl_sh[2];
  assign line.scl_fall = ~scl_sh[1] & scl_sh[2];
  // data edges only count while the clock stays high
  assign line.start    = scl_sh[1] & scl_sh[2] & ~sda_sh[1] & sda_sh[2];
  assign line.stop     = scl_sh[1] & scl_sh[2] & sda_sh[1] & ~sda_sh[2];
endmodule : rtcif_line_sync
`default_nettype wire

// >>> rtl/rtcif_pkg.sv
// rtcif_pkg: shared constants, types and address mapping for the rtc serial slave port
`default_nettype none
package rtcif_pkg;
  // full address bytes, direction bit included
  localparam logic [7:0] ADDR_WRITE    = 8'hAC;
  localparam logic [7:0] ADDR_READ     = 8'hAD;
  // memory pages that are held in the cache
  localparam logic [4:0] PAGE_WATCH    = 5'h01;
  localparam logic [4:0] PAGE_ALARM    = 5'h02;
  localparam logic [4:0] PAGE_TIMER    = 5'h03;
  localparam logic [4:0] PAGE_TEMP     = 5'h04;
  localparam int         CACHE_WORDS   = 32;
  localparam logic [5:0] ENG_LAST      = 6'h20;  // copy engine stops at this index
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;
  localparam logic [3:0] BIT_LAST      = 4'h7;
  localparam logic [7:0] PTR_RESET     = 8'h00;  // page and word pointer after reset
  localparam logic [7:0] UNCACHED_READ = 8'h00;  // read value of a page not in the cache
  localparam logic [2:0] WORD_STEP     = 3'h1;

  typedef enum logic [2:0] {S_IDLE, S_RX, S_RX_ACK, S_TX, S_TX_ACK, S_IGNORE} rtcif_state_t;
  typedef enum logic [1:0] {K_ADDR, K_WORD, K_DATA} rtcif_kind_t;
  typedef enum logic [1:0] {E_IDLE, E_SNAP, E_WB} rtcif_eng_t;

  // true when a page lies in the cached range
  function automatic logic rtcif_cached(input logic [7:0] ptr);
    rtcif_cached = (ptr[7:3] >= PAGE_WATCH) && (ptr[7:3] <= PAGE_TEMP);
  endfunction : rtcif_cached

  // cache index of a page and word pointer
  function automatic logic [4:0] rtcif_index(input logic [7:0] ptr);
    logic [4:0] slot;
    slot = ptr[7:3] - PAGE_WATCH;
    rtcif_index = {slot[1:0], ptr[2:0]};
  endfunction : rtcif_index

  // live register address of a cache index
  function automatic logic [7:0] rtcif_live(input logic [4:0] idx);
    rtcif_live = {5'(idx[4:3]) + PAGE_WATCH, idx[2:0]};
  endfunction : rtcif_live
endpackage : rtcif_pkg
`default_nettype wire

// >>> rtl/rtcif_slave.sv
// rtcif_slave: two-wire slave port of the rtc with a snapshot cache of the clock register pages
`default_nettype none
module rtcif_slave
  import rtcif_pkg::*;
(
  input  wire logic       clock_in,          // system clock, 10 MHz
  input  wire logic       arst_n_in,         // async reset, active low
  input  wire logic       scl_in,            // serial clock pin
  input  wire logic       sda_in,            // serial data pin level
  output logic            sda_out,           // serial data drive value, always low
  output logic            sda_oe_out,        // high while pulling data low
  output logic [7:0]      live_addr_out,     // live register page and word
  input  wire logic [7:0] live_rd_data_in,   // live register value, in the same cycle as the address
  output logic            live_wr_en_out,    // write strobe to live registers
  output logic [7:0]      live_wr_data_out,  // value for live register write
  output logic            busy_out           // transfer or copy in progress
);
  rtcif_line_if line ();

  rtcif_line_sync u_sync (
    .clock_in  (clock_in),
    .arst_n_in (arst_n_in),
    .scl_in    (scl_in),
    .sda_in    (sda_in),
    .line      (line)
  );

  rtcif_state_t state, next_state;
  rtcif_kind_t  kind, next_kind;
  logic [3:0]   bitcnt, next_bitcnt;
  logic [7:0]   shreg, next_shreg;
  logic [7:0]   ptr, next_ptr;
  logic         wr_mode, next_wr_mode;
  logic         oe, next_oe;
  logic         acked, next_acked;
  logic         cache_we;
  logic [7:0]   cache [CACHE_WORDS];
  logic [7:0]   ptr_inc;
  logic [7:0]   rd_now, rd_inc;

  // word steps within its page, the page never changes by itself
  assign ptr_inc = {ptr[7:3], ptr[2:0] + WORD_STEP};
  assign rd_now  = rtcif_cached(ptr) ? cache[rtcif_index(ptr)] : UNCACHED_READ;
  assign rd_inc  = rtcif_cached(ptr_inc) ? cache[rtcif_index(ptr_inc)] : UNCACHED_READ;

  // byte level protocol: drive changes only on clock falls so data stays steady while high
  always_comb begin
    next_state   = state;
    next_kind    = kind;
    next_bitcnt  = bitcnt;
    next_shreg   = shreg;
    next_ptr     = ptr;
    next_wr_mode = wr_mode;
    next_oe      = oe;
    next_acked   = acked;
    cache_we     = 1'b0;
    if (line.stop) begin
      next_state = S_IDLE;
      next_oe    = 1'b0;
    end else if (line.start) begin
      next_state  = S_RX;
      next_kind   = K_ADDR;
      next_bitcnt = 4'h0;
      next_oe     = 1'b0;
    end else begin
      unique case (state)
        S_IDLE, S_IGNORE: next_oe = 1'b0;
        S_RX: begin
          if (line.scl_rise) begin
            next_shreg  = {shreg[6:0], line.sda};
            next_bitcnt = bitcnt + 4'h1;
          end else if (line.scl_fall && bitcnt == BITS_PER_BYTE) begin
            next_state = S_RX_ACK;
            next_oe    = 1'b1;
            unique case (kind)
              K_ADDR: begin
                if (shreg == ADDR_WRITE) begin
                  next_wr_mode = 1'b1;
                end else if (shreg == ADDR_READ) begin
                  next_wr_mode = 1'b0;
                end else begin
                  next_state = S_IGNORE;
                  next_oe    = 1'b0;
                end
              end
              K_WORD: next_ptr = shreg;
              K_DATA: begin
                cache_we = 1'b1;
                next_ptr = ptr_inc;
              end
              default: next_state = S_IGNORE;
            endcase
          end
        end
        S_RX_ACK: begin
          // held low over the whole high phase; on the closing fall, released, or set to the first bit after a read address
          if (line.scl_fall) begin
            next_bitcnt = 4'h0;
            if (kind == K_ADDR && !wr_mode) begin
              next_state = S_TX;
              next_shreg = rd_now;
              next_oe    = ~rd_now[7];
            end else begin
              next_state = S_RX;
              next_oe    = 1'b0;
              next_kind  = (kind == K_ADDR) ? K_WORD : K_DATA;
            end
          end
        end
        S_TX: begin
          if (line.scl_fall) begin
            if (bitcnt == BIT_LAST) begin
              next_state = S_TX_ACK;
              next_oe    = 1'b0;
            end else begin
              next_bitcnt = bitcnt + 4'h1;
              next_shreg  = {shreg[6:0], 1'b0};
              next_oe     = ~shreg[6];
            end
          end
        end
        S_TX_ACK: begin
          if (line.scl_rise) begin
            next_acked = ~line.sda;
          end else if (line.scl_fall) begin
            if (acked) begin
              next_ptr    = ptr_inc;
              next_state  = S_TX;
              next_bitcnt = 4'h0;
              next_shreg  = rd_inc;
              next_oe     = ~rd_inc[7];
            end else begin
              next_state = S_IGNORE;
            end
          end
        end
        default: next_state = S_IDLE;
      endcase
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      state   <= S_IDLE;
      kind    <= K_ADDR;
      bitcnt  <= 4'h0;
      shreg   <= 8'h00;
      ptr     <= PTR_RESET;
      wr_mode <= 1'b0;
      oe      <= 1'b0;
      acked   <= 1'b0;
    end else begin
      state   <= next_state;
      kind    <= next_kind;
      bitcnt  <= next_bitcnt;
      shreg   <= next_shreg;
      ptr     <= next_ptr;
      wr_mode <= next_wr_mode;
      oe      <= next_oe;
      acked   <= next_acked;
    end
  end

  // copy engine: snapshot on opening condition, write back dirty words after a write transfer
  rtcif_eng_t  eng, next_eng;
  logic [5:0]  eidx, next_eidx;
  logic        snap_pend, next_snap_pend;
  logic        cap_vld, next_cap_vld;
  logic [4:0]  cap_idx, next_cap_idx;
  logic [31:0] dirty, next_dirty;
  logic [7:0]  next_live_addr;
  logic        next_live_wr_en;
  logic [7:0]  next_live_wr_data;

  always_comb begin
    next_eng          = eng;
    next_eidx         = eidx;
    next_snap_pend    = snap_pend;
    next_cap_vld      = 1'b0;
    next_cap_idx      = cap_idx;
    next_dirty        = dirty;
    next_live_addr    = live_addr_out;
    next_live_wr_en   = 1'b0;
    next_live_wr_data = live_wr_data_out;
    if (line.start) begin
      next_snap_pend = 1'b1;
    end
    unique case (eng)
      E_IDLE: begin
        next_eidx = 6'h00;
        if (line.stop && wr_mode && state != S_IGNORE && dirty != 32'h0) begin
          next_eng = E_WB;
        end else if (snap_pend) begin
          next_eng       = E_SNAP;
          next_snap_pend = line.start;
          next_dirty     = 32'h0;
        end
      end
      E_SNAP: begin
        // a one-shot copy; nothing refreshes the cache until the next opening condition
        if (eidx == ENG_LAST) begin
          next_eng = E_IDLE;
        end else begin
          next_live_addr = rtcif_live(eidx[4:0]);
          next_cap_idx   = eidx[4:0];
          next_cap_vld   = 1'b1;
          next_eidx      = eidx + 6'h01;
        end
      end
      E_WB: begin
        if (eidx == ENG_LAST) begin
          next_eng = E_IDLE;
        end else begin
          if (dirty[eidx[4:0]]) begin
            next_live_addr    = rtcif_live(eidx[4:0]);
            next_live_wr_data = cache[eidx[4:0]];
            next_live_wr_en   = 1'b1;
            next_dirty[eidx[4:0]] = 1'b0;
          end
          next_eidx = eidx + 6'h01;
        end
      end
      default: next_eng = E_IDLE;
    endcase
    // a serial write marks its word, winning over any clear in the same cycle
    if (cache_we && rtcif_cached(ptr)) begin
      next_dirty[rtcif_index(ptr)] = 1'b1;
    end
  end

  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      eng              <= E_IDLE;
      eidx             <= 6'h00;
      snap_pend        <= 1'b0;
      cap_vld          <= 1'b0;
      cap_idx          <= 5'h00;
      dirty            <= 32'h0;
      live_addr_out    <= 8'h00;
      live_wr_en_out   <= 1'b0;
      live_wr_data_out <= 8'h00;
    end else begin
      eng              <= next_eng;
      eidx             <= next_eidx;
      snap_pend        <= next_snap_pend;
      cap_vld          <= next_cap_vld;
      cap_idx          <= next_cap_idx;
      dirty            <= next_dirty;
      live_addr_out    <= next_live_addr;
      live_wr_en_out   <= next_live_wr_en;
      live_wr_data_out <= next_live_wr_data;
    end
  end

  // cache storage: serial writes or snapshot captures; pages outside the cache drop writes
  always_ff @(posedge clock_in) begin
    if (cache_we && rtcif_cached(ptr)) begin
      cache[rtcif_index(ptr)] <= shreg;
    end else if (cap_vld) begin
      cache[cap_idx] <= live_rd_data_in;
    end
  end

  // pin drive is open drain: value fixed low, only the enable moves
  always_ff @(posedge clock_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      sda_out    <= 1'b0;
      sda_oe_out <= 1'b0;
      busy_out   <= 1'b0;
    end else begin
      sda_out    <= 1'b0;
      sda_oe_out <= next_oe;
      busy_out   <= (next_state != S_IDLE) || (next_eng != E_IDLE);
    end
  end

  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!arst_n_in);

  open_drain_a: assert property (sda_oe_out |-> !sda_out) else $error("data pin driven high");
  steady_high_a: assert property (line.scl && $past(line.scl) && !line.start && !line.stop
    |-> ##1 $stable(sda_oe_out)) else $error("data drive moved while clock high");
  start_rx_a: assert property (line.start && !line.stop
    |=> state == S_RX && kind == K_ADDR && bitcnt == 4'h0) else $error("opening condition not taken");
  stop_idle_a: assert property (line.stop |=> state == S_IDLE ##1 !sda_oe_out)
    else $error("closing condition ignored");
  rx_ack_a: assert property (state == S_RX && kind != K_ADDR && line.scl_fall && bitcnt == BITS_PER_BYTE
    && !line.start && !line.stop |=> ##1 sda_oe_out) else $error("received byte not acknowledged");
  nack_release_a: assert property (state == S_TX_ACK && line.scl_fall && !acked && !line.start
    && !line.stop |=> state == S_IGNORE ##1 !sda_oe_out) else $error("data line held after missing ack");
  bad_addr_a: assert property (state == S_RX && kind == K_ADDR && line.scl_fall && bitcnt == BITS_PER_BYTE
    && shreg != ADDR_WRITE && shreg != ADDR_READ && !line.start && !line.stop |=> state == S_IGNORE)
    else $error("foreign address accepted");
  word_step_a: assert property (state == S_TX_ACK && line.scl_fall && acked && !line.start && !line.stop
    |=> ptr[7:3] == $past(ptr[7:3]) && ptr[2:0] == $past(ptr[2:0]) + WORD_STEP) else $error("word step wrong");
  wb_only_dirty_a: assert property (eng == E_WB && !dirty[eidx[4:0]] && eidx != ENG_LAST
    |=> !live_wr_en_out) else $error("clean word written back");
  mode_pick_a: assert property (state == S_RX && kind == K_ADDR && line.scl_fall && bitcnt == BITS_PER_BYTE
    && shreg == ADDR_READ && !line.start && !line.stop |=> !wr_mode ##[1:20] state == S_TX)
    else $error("read address not taken as read");
endmodule : rtcif_slave
`default_nettype wire

// >>> sim/rtc_i2c_slave_cached_access_tb_top.sv
// rtc_i2c_slave_cached_access_tb_top: self-checking bench of the rtc serial slave port
`default_nettype none
module rtc_i2c_slave_cached_access_tb_top
  import rtcif_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic       clock_in;
  logic       arst_n_in;
  logic       scl;
  logic       m_oe;
  logic       d_oe;
  logic       d_drv;
  wire logic  sda_line;
  logic [7:0] live_addr;
  logic [7:0] live [256];
  logic       wr_en;
  logic [7:0] wr_data;
  logic       busy;
  logic       ack;
  logic [7:0] rd;
  int         fails = 0;
  int         samples_checked = 0;
  int         writes = 0;

  // open-drain data line with pull-up
  assign sda_line = ~m_oe & (~d_oe | d_drv);

  rtcif_slave dut (
    .clock_in         (clock_in),
    .arst_n_in        (arst_n_in),
    .scl_in           (scl),
    .sda_in           (sda_line),
    .sda_out          (d_drv),
    .sda_oe_out       (d_oe),
    .live_addr_out    (live_addr),
    .live_rd_data_in  (live[live_addr]),
    .live_wr_en_out   (wr_en),
    .live_wr_data_out (wr_data),
    .busy_out         (busy)
  );

  rtcif_master m (
    .clock_in   (clock_in),
    .sda_in     (sda_line),
    .scl_out    (scl),
    .sda_oe_out (m_oe)
  );

  // live registers take the copy-back strobes; counting them shows what was written
  always @(posedge clock_in) begin
    if (wr_en === 1'b1) begin
      live[live_addr] <= wr_data;
      writes <= writes + 1;
    end
  end

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fails++;
      $display("wrong value at %0t ns: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check

  // send a byte and expect the slave to pull the line low in the answer slot
  task automatic put_ok(input logic [7:0] d);
    m.put(d, ack);
    check({7'h00, ack}, 8'h00);
  endtask : put_ok

  // two bytes from the last word of the watch page: the second wraps inside the page
  task automatic t_write_wrap;
    int w0;
    w0 = writes;
    m.start();
    put_ok(ADDR_WRITE);
    put_ok(8'h0F);
    put_ok(8'hA5);
    put_ok(8'h3C);
    m.stop();
    check(live[8'h0F], 8'hA5);
    check(live[8'h08], 8'h3C);
    check(live[8'h09], 8'h39);
    check(8'(writes - w0), 8'h02);
    check({7'h00, busy}, 8'h00);
  endtask : t_write_wrap

  // read on from word 09, where the write left the pointer, while timekeeping changes a cached word under it
  task automatic t_read_cont;
    int w0;
    w0 = writes;
    m.start();
    put_ok(ADDR_READ);
    live[8'h09] <= 8'hEE;  // timekeeping tick during the transfer
    m.get(1'b1, rd);
    check(rd, 8'h39);
    m.get(1'b0, rd);
    check(rd, 8'h3A);
    m.stop();
    check(8'(writes - w0), 8'h00);
    m.start();
    put_ok(ADDR_READ);
    m.get(1'b0, rd);
    check(rd, 8'h3A);
    m.stop();
  endtask : t_read_cont

  // set a location, then read it in a new transfer that snapshots the changed word
  task automatic t_read_at;
    m.start();
    put_ok(ADDR_WRITE);
    put_ok(8'h09);
    m.stop();
    m.start();
    put_ok(ADDR_READ);
    m.get(1'b0, rd);
    check(rd, 8'hEE);
    m.stop();
  endtask : t_read_at

  // a foreign address must leave the line free and the pointer untouched
  task automatic t_foreign;
    int w0;
    w0 = writes;
    m.start();
    m.put(8'hAE, ack);
    check({7'h00, ack}, 8'h01);
    m.put(8'h0A, ack);
    check({7'h00, ack}, 8'h01);
    m.put(8'h55, ack);
    check({7'h00, ack}, 8'h01);
    m.stop();
    check(8'(writes - w0), 8'h00);
    m.start();
    put_ok(ADDR_READ);
    m.get(1'b0, rd);
    check(rd, 8'hEE);
    m.stop();
  endtask : t_foreign

  // a page outside the cache drops writes and reads back the fixed uncached value
  task automatic t_uncached;
    int w0;
    w0 = writes;
    m.start();
    put_ok(ADDR_WRITE);
    put_ok(8'h00);
    put_ok(8'h77);
    m.stop();
    check(8'(writes - w0), 8'h00);
    check(live[8'h00], 8'h30);
    check({7'h00, busy}, 8'h00);
    m.start();
    put_ok(ADDR_READ);
    m.get(1'b0, rd);
    check(rd, UNCACHED_READ);
    m.stop();
  endtask : t_uncached

  task automatic finish_test;
    $display("comparisons %0d, mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : finish_test

  // free-running system clock
  initial begin
    clock_in = 1'b0;
    forever #50 clock_in = ~clock_in;
  end

  // a hang in the slave's handshake must still end the run
  initial begin
    #(30000 * 100);
    fails++;
    finish_test();
  end

  // reset, then the scenarios in order; each leaves the pointer where the next expects it
  initial begin
    arst_n_in = 1'b0;
    for (int i = 0; i < 256; i++) live[i] = 8'(i) + 8'h30;
    repeat (10) @(posedge clock_in);
    arst_n_in <= 1'b1;
    repeat (4) @(posedge clock_in);
    check({7'h00, d_oe}, 8'h00);
    check({7'h00, busy}, 8'h00);
    t_write_wrap();
    t_read_cont();
    t_read_at();
    t_foreign();
    t_uncached();
    check(8'(m.unstable), 8'h00);
    finish_test();
  end
endmodule : rtc_i2c_slave_cached_access_tb_top
`default_nettype wire

// >>> sim/rtcif_master.sv
// rtcif_master: behavioural bus master that clocks the rtc slave port
`default_nettype none
module rtcif_master (
  input  wire logic clock_in,   // system clock
  input  wire logic sda_in,     // resolved data line level
  output var logic  scl_out,    // clock line, driven by the master only
  output var logic  sda_oe_out  // high while pulling the data line low
);
  timeunit 1ns;
  timeprecision 1ns;
  int unstable = 0;  // data changes seen while the clock was high

  // idle bus: both lines high
  initial begin
    scl_out = 1'b1;
    sda_oe_out = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock_in);
  endtask : wait_clk

  // one clock pulse of 8 cycles: data set inside the low phase, sampled twice in the high phase
  task automatic bit_io(input logic b, output logic s);
    logic early;
    wait_clk(2);
    sda_oe_out <= ~b;
    wait_clk(2);
    scl_out <= 1'b1;
    wait_clk(2);
    early = sda_in;
    wait_clk(1);
    s = sda_in;
    if (early !== s) unstable++;
    wait_clk(1);
    scl_out <= 1'b0;
  endtask : bit_io

  // opening condition from an idle bus
  task automatic start;
    wait_clk(4);
    sda_oe_out <= 1'b1;
    wait_clk(4);
    scl_out <= 1'b0;
  endtask : start

  // closing condition; the long tail leaves room for the copy-back
  task automatic stop;
    wait_clk(2);
    sda_oe_out <= 1'b1;
    wait_clk(2);
    scl_out <= 1'b1;
    wait_clk(4);
    sda_oe_out <= 1'b0;
    wait_clk(48);
  endtask : stop

  // send a byte msb first, then release the line for the slave's answer
  task automatic put(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, ack);
  endtask : put

  // receive a byte, then acknowledge it or leave it unacknowledged to end the read
  task automatic get(input logic give_ack, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(~give_ack, s);
  endtask : get
endmodule : rtcif_master
`default_nettype wire
